/* File: crsl_code_rom_security_lock.sv */
`timescale 1ns/1ps
module crsl_code_rom_security_lock #(
  parameter int CODE_AW = 12,
  parameter int KEY_AW  = 6
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         optionByte,
  output logic      [12:0]        optionAddr,
  input  wire logic               externalAccessSelect,
  input  wire logic               tableReadReq,
  input  wire logic               tableReadFromExternal,
  input  wire logic [CODE_AW-1:0] tableReadAddr,
  output logic      [7:0]         tableReadData,
  output logic                    tableReadValid,
  input  wire logic               verifyReq,
  input  wire logic [CODE_AW-1:0] verifyAddr,
  output logic      [7:0]         verifyData,
  output logic                    verifyValid,
  input  wire logic               programReq,
  output logic                    programAllowed,
  output logic                    externalAccessLatched,
  output logic                    lockBitFirst,
  output logic                    lockBitSecond,
  output logic                    keyProgrammed,
  output logic                    loadDone
);
  if (CODE_AW != $clog2(crsl_pkg::CODE_BYTES) || KEY_AW != $clog2(crsl_pkg::KEY_BYTES)) begin : crsl_width_check
    $error("crsl: address widths must match the option image layout");
  end

  typedef enum logic [2:0] {
    CRSL_LOAD_CODE = 3'b001,
    CRSL_LOAD_KEY  = 3'b010,
    CRSL_RUN       = 3'b100
  } crsl_state_e;

  crsl_state_e       state, next_state;
  logic [12:0]       addr, next_addr;
  logic [7:0]        codeMem [crsl_pkg::CODE_BYTES];
  logic [7:0]        keyMem  [crsl_pkg::KEY_BYTES];
  logic              lockFirst, next_lockFirst, lockSecond, next_lockSecond;
  logic              keyProg, next_keyProg, eaLatch, next_eaLatch;
  logic              eaTaken, next_eaTaken;
  logic [7:0]        trData, next_trData, vfData, next_vfData;
  logic              trValid, next_trValid, vfValid, next_vfValid, progOk, next_progOk;
  logic              running, next_running;

  function automatic logic [7:0] crsl_encrypt(input logic [7:0] code, input logic [7:0] key);
    crsl_encrypt = ~(code ^ key);
  endfunction

  // Image load: code, then key, then the lock byte; locks freeze once running.
  always_comb begin
    next_state      = state;
    next_addr       = addr;
    next_lockFirst  = lockFirst;
    next_lockSecond = lockSecond;
    next_keyProg    = keyProg;
    unique case (state)
      CRSL_LOAD_CODE: begin
        next_addr = addr + 13'h0001;
        if (addr == crsl_pkg::CODE_LAST_ADDR) next_state = CRSL_LOAD_KEY;
      end
      CRSL_LOAD_KEY: begin
        next_addr = addr + 13'h0001;
        if (addr <= crsl_pkg::KEY_LAST_ADDR && optionByte != crsl_pkg::KEY_ERASED) next_keyProg = 1'b1;
        if (addr == crsl_pkg::LOCK_BYTE_ADDR) begin
          next_lockFirst  = ~optionByte[crsl_pkg::LOCK_FIRST_POS];
          next_lockSecond = ~optionByte[crsl_pkg::LOCK_SECOND_POS];
          next_state      = CRSL_RUN;
          next_addr       = addr;
        end
      end
      CRSL_RUN: begin
      end
    endcase
    next_running = next_state == CRSL_RUN;
  end

  // Writes only fill memories; the key array reaches a data output only as mixed into verifyData by crsl_encrypt.
  always_ff @(posedge ref_clk) begin
    if (state == CRSL_LOAD_CODE) codeMem[addr[11:0]] <= optionByte;
    if (state == CRSL_LOAD_KEY && addr <= crsl_pkg::KEY_LAST_ADDR) keyMem[addr[5:0]] <= optionByte;
  end

  // Programmed lock bit reads as zero in the image, so both erased means unlocked.
  always_comb begin
    logic lockBoth;
    lockBoth      = lockFirst & lockSecond;
    next_eaLatch  = eaLatch;
    next_eaTaken  = eaTaken;
    next_trValid  = 1'b0;
    next_vfValid  = 1'b0;
    next_trData   = trData;
    next_vfData   = vfData;
    next_progOk   = 1'b0;
    if (!eaTaken) begin
      next_eaLatch = externalAccessSelect;
      next_eaTaken = 1'b1;
    end else if (!lockFirst) begin
      next_eaLatch = externalAccessSelect;
    end
    if (state == CRSL_RUN) begin
      next_progOk = programReq & ~lockFirst;
      if (tableReadReq) begin
        next_trValid = 1'b1;
        next_trData  = (lockFirst && tableReadFromExternal) ? crsl_pkg::TABLE_BLOCKED : codeMem[tableReadAddr];
      end
      if (verifyReq && !lockBoth) begin
        next_vfValid = 1'b1;
        next_vfData  = keyProg ? crsl_encrypt(codeMem[verifyAddr], keyMem[verifyAddr[KEY_AW-1:0]])
                               : codeMem[verifyAddr];
      end else if (verifyReq) begin
        next_vfData = crsl_pkg::VERIFY_BLOCKED;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= CRSL_LOAD_CODE;
      addr       <= crsl_pkg::CODE_FIRST_ADDR;
      lockFirst  <= 1'b1;
      lockSecond <= 1'b1;
      keyProg    <= 1'b0;
      eaLatch    <= 1'b0;
      eaTaken    <= 1'b0;
      trData     <= 8'h00;
      vfData     <= 8'h00;
      trValid    <= 1'b0;
      vfValid    <= 1'b0;
      progOk     <= 1'b0;
      running    <= 1'b0;
    end else begin
      state      <= next_state;
      addr       <= next_addr;
      lockFirst  <= next_lockFirst;
      lockSecond <= next_lockSecond;
      keyProg    <= next_keyProg;
      eaLatch    <= next_eaLatch;
      eaTaken    <= next_eaTaken;
      trData     <= next_trData;
      vfData     <= next_vfData;
      trValid    <= next_trValid;
      vfValid    <= next_vfValid;
      progOk     <= next_progOk;
      running    <= next_running;
    end
  end

  // Locks reset to the safe, locked value so nothing leaks before the image is read.
  always_comb begin
    optionAddr            = addr;
    tableReadData         = trData;
    tableReadValid        = trValid;
    verifyData            = vfData;
    verifyValid           = vfValid;
    programAllowed        = progOk;
    externalAccessLatched = eaLatch;
    lockBitFirst          = lockFirst;
    lockBitSecond         = lockSecond;
    keyProgrammed         = keyProg;
    loadDone              = running;
  end

  prog_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lockFirst |=> !programAllowed) else $error("programming allowed while locked");
  ea_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lockFirst && $past(eaTaken)) |=> $stable(externalAccessLatched)) else $error("latched select moved");
  ea_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (loadDone && !lockFirst) |=> externalAccessLatched == $past(externalAccessSelect))
    else $error("unlocked select not followed");
  table_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (loadDone && lockFirst && tableReadReq && tableReadFromExternal) |=> tableReadValid
    && tableReadData == crsl_pkg::TABLE_BLOCKED) else $error("external table read leaked");
  table_open_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (loadDone && tableReadReq && !(lockFirst && tableReadFromExternal)) |=> tableReadValid
    && tableReadData == codeMem[$past(tableReadAddr)]) else $error("table read data wrong");
  verify_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lockFirst && lockSecond) |=> !verifyValid) else $error("verify while fully locked");
  verify_blank_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (loadDone && lockFirst && lockSecond && verifyReq) |=> verifyData == crsl_pkg::VERIFY_BLOCKED)
    else $error("blocked verify data not blanked");
  second_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (loadDone && !lockFirst && verifyReq) |=> verifyValid) else $error("second bit alone blocked verify");
  second_alone_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (loadDone && !lockFirst && lockSecond && programReq) |=> programAllowed)
    else $error("second bit alone refused programming");
  plain_verify_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (loadDone && !lockFirst && !keyProgrammed && verifyReq) |=> verifyData == codeMem[$past(verifyAddr)])
    else $error("plain verify data wrong");
  load_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!loadDone && (verifyReq || tableReadReq || programReq)) |=>
    !(verifyValid || tableReadValid || programAllowed)) else $error("request answered during load");
  lock_const_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(loadDone) |-> $stable(lockFirst) && $stable(lockSecond)) else $error("lock changed while running");
  load_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(loadDone) |-> optionAddr == crsl_pkg::LOCK_BYTE_ADDR) else $error("lock byte address wrong");
  crypt_verify_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (loadDone && !lockFirst && keyProgrammed && verifyReq) |=> verifyData ==
    crsl_encrypt(codeMem[$past(verifyAddr)], keyMem[$past(verifyAddr[5:0])])) else $error("encrypt wrong");

  // Covers mark the end of the load, an encrypted verify, each lock bit set, and programming allowed.
  cov_load_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(loadDone));
  cov_crypt_c: cover property (@(posedge ref_clk) disable iff (!rst_n) verifyValid && keyProgrammed);
  cov_block_c: cover property (@(posedge ref_clk) disable iff (!rst_n) tableReadValid && lockBitFirst);
  cov_refuse_c: cover property (@(posedge ref_clk) disable iff (!rst_n) verifyReq && loadDone && lockBitSecond);
  cov_open_c: cover property (@(posedge ref_clk) disable iff (!rst_n) programAllowed);
endmodule

/* File: crsl_pkg.sv */
package crsl_pkg;
  localparam int          CODE_BYTES      = 4096;
  localparam int          KEY_BYTES       = 64;
  localparam logic [12:0] CODE_FIRST_ADDR = 13'h0000;
  localparam logic [12:0] CODE_LAST_ADDR  = 13'h0FFF;
  localparam logic [12:0] KEY_FIRST_ADDR  = 13'h1000;
  localparam logic [12:0] KEY_LAST_ADDR   = 13'h103F;
  localparam logic [12:0] LOCK_BYTE_ADDR  = 13'h1040;
  localparam int          LOCK_FIRST_POS  = 0;
  localparam int          LOCK_SECOND_POS = 1;
  localparam logic [7:0]  KEY_ERASED      = 8'hFF;
  localparam logic [7:0]  VERIFY_BLOCKED  = 8'hFF;
  localparam logic [7:0]  TABLE_BLOCKED   = 8'hFF;
endpackage

/* File: crsl_option_store.sv */
`timescale 1ns/1ps
// Combinational option image, as the outside store presents it to the loader.
module crsl_option_store (
  input  wire logic [12:0] addr,
  input  wire logic [7:0]  lockByte,
  input  wire logic        keyOn,
  output logic      [7:0]  data
);
  always_comb begin
    if (addr <= crsl_pkg::CODE_LAST_ADDR) begin
      data = addr[7:0] ^ {addr[11:8], 4'h6};
    end else if (addr <= crsl_pkg::KEY_LAST_ADDR) begin
      data = keyOn ? 8'h5A + {2'h0, addr[5:0]} : crsl_pkg::KEY_ERASED;
    end else if (addr == crsl_pkg::LOCK_BYTE_ADDR) begin
      data = lockByte;
    end else begin
      data = 8'hFF;
    end
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk, rst_n, externalAccessSelect, tableReadReq, tableReadFromExternal, verifyReq, programReq;
  logic        tableReadValid, verifyValid, programAllowed, externalAccessLatched, keyOn;
  logic        lockBitFirst, lockBitSecond, keyProgrammed, loadDone;
  logic [11:0] tableReadAddr, verifyAddr;
  logic [7:0]  optionByte, tableReadData, verifyData, lockByte;
  logic [12:0] optionAddr;
  int          n_mismatch = 0;
  int          checked = 0;
  crsl_code_rom_security_lock crsl_code_rom_security_lock_i (.ref_clk, .rst_n, .optionByte, .optionAddr,
    .externalAccessSelect, .tableReadReq, .tableReadFromExternal, .tableReadAddr, .tableReadData,
    .tableReadValid, .verifyReq, .verifyAddr, .verifyData, .verifyValid, .programReq, .programAllowed,
    .externalAccessLatched, .lockBitFirst, .lockBitSecond, .keyProgrammed, .loadDone);
  crsl_option_store crsl_option_store_i (.addr(optionAddr), .lockByte, .keyOn, .data(optionByte));
  function automatic logic [7:0] codeOf(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'h6};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Each configuration needs a full reload, so every call costs some 4260 cycles.
  task automatic run(input logic [7:0] lb, input logic kOn);
    logic       first, both, pin;
    logic [7:0] exp;
    first = !lb[0];
    both = first && !lb[1];
    pin = 1'($urandom);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    lockByte <= lb;
    keyOn <= kOn;
    externalAccessSelect <= pin;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    {verifyReq, tableReadReq, programReq} <= 3'b111;
    repeat (crsl_pkg::CODE_BYTES + crsl_pkg::KEY_BYTES) @(posedge ref_clk);
    {verifyReq, tableReadReq, programReq} <= 3'b000;
    #1;
    chk("loadDone", 8'h00, 8'(loadDone));
    chk("earlyAnswer", 8'h00, {5'h00, verifyValid, tableReadValid, programAllowed});
    @(posedge ref_clk);
    #1;
    chk("loadDone", 8'h01, 8'(loadDone));
    chk("optionAddr", 8'h01, 8'(optionAddr == crsl_pkg::LOCK_BYTE_ADDR));
    chk("lockBitFirst", 8'(first), 8'(lockBitFirst));
    chk("lockBitSecond", 8'(!lb[1]), 8'(lockBitSecond));
    chk("keyProgrammed", 8'(kOn), 8'(keyProgrammed));
    repeat (40) begin
      @(posedge ref_clk);
      verifyReq <= 1'b1;
      tableReadReq <= 1'b1;
      programReq <= 1'b1;
      verifyAddr <= 12'($urandom);
      tableReadAddr <= 12'($urandom);
      tableReadFromExternal <= 1'($urandom);
      @(posedge ref_clk);
      verifyReq <= 1'b0;
      tableReadReq <= 1'b0;
      programReq <= 1'b0;
      #1;
      exp = kOn ? ~(codeOf(verifyAddr) ^ (8'h5A + {2'h0, verifyAddr[5:0]})) : codeOf(verifyAddr);
      chk("verifyValid", 8'(!both), 8'(verifyValid));
      chk("verifyData", both ? 8'hFF : exp, verifyData);
      chk("tableReadData", first && tableReadFromExternal ? 8'hFF : codeOf(tableReadAddr), tableReadData);
      chk("tableReadValid", 8'h01, 8'(tableReadValid));
      chk("programAllowed", 8'(!first), 8'(programAllowed));
    end
    @(posedge ref_clk);
    externalAccessSelect <= !pin;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("externalAccessLatched", 8'(first ? pin : !pin), 8'(externalAccessLatched));
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    rst_n = 1'b0;
    {externalAccessSelect, tableReadReq, tableReadFromExternal, verifyReq, programReq, keyOn} = '0;
    {tableReadAddr, verifyAddr} = '0;
    lockByte = 8'hFF;
    void'($urandom(74));
    repeat (12) @(posedge ref_clk);
    run(8'hFF, 1'b0);
    run(8'hFF, 1'b1);
    run(8'hFE, 1'b1);
    run(8'hFC, 1'b0);
    run(8'hFD, 1'b1);
    report_and_stop;
  end
  initial begin
    #1_000_000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
